// [usb_soft_detach_descriptor_select_tb.sv]
/*
 * Self-checking bench: identify, detach, reattach, descriptor streams.
 * Assumes the core, its defines, the checker and the port model.
 */
`timescale 1ns/1ps
`include "usbsd_defs.vh"
module usb_soft_detach_descriptor_select_tb;
    localparam int DET = 50;
    localparam int RXTO = 40;
    logic clk_sys = 1'b0, rst_b = 1'b0, plugged = 1'b0, kbd_mode = 1'b0;
    logic kbm_clk_i, kbm_clk_o, kbm_clk_oe_b, kbm_dat_i, kbm_dat_o;
    logic kbm_dat_oe_b, kbm_rx_valid_q, keyboard_present_flag, cmd_ok;
    logic bus_attach_control, usb_interface_init, usb_core_hold, usb_ready;
    logic usb_enum_done = 1'b0, desc_req = 1'b0, desc_ready = 1'b0;
    logic desc_busy, desc_stall_q, desc_valid_q, desc_last_q;
    logic [1:0] desc_kind = 2'h0;
    logic [7:0] desc_index = 8'h00, kbm_rx_byte_q, desc_byte_q, desc_rom_data;
    logic [9:0] desc_max_len = 10'h000, desc_rom_addr_q;
    int error_cnt = 0;
    int total_checks = 0;
    always #5 clk_sys = ~clk_sys;
    // Last byte passed on in normal operation; the pulse is one cycle
    logic [7:0] rx_seen = 8'h00;
    always @(posedge clk_sys)
        if (kbm_rx_valid_q === 1'b1)
            rx_seen <= kbm_rx_byte_q;
    // Small counts keep the run short
    usbsd_core #(.DETACH_CYC(DET), .RX_TO_CYC(RXTO), .ID_WAIT_CYC(60),
        .SETTLE_CYC(20)) usbsd_core_inst (.*);
    usbsd_kbm_model usbsd_kbm_model_inst (.clk_sys(clk_sys),
        .plugged(plugged), .kbd_mode(kbd_mode), .kbm_clk_oe_b(kbm_clk_oe_b),
        .kbm_dat_oe_b(kbm_dat_oe_b), .kbm_clk_i(kbm_clk_i),
        .kbm_dat_i(kbm_dat_i), .cmd_ok(cmd_ok));
    function automatic logic [7:0] rom_at(input logic [9:0] a);
        return a[7:0] ^ {6'h0, a[9:8]};
    endfunction
    assign desc_rom_data = rom_at(desc_rom_addr_q);
    ////////////////////////////////////////
    task close_out;
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wait_val(const ref logic s, input logic v, input int lim);
        int n;
        for (n = 0; n < lim && s !== v; n++) @(posedge clk_sys);
        if (n >= lim) begin
            error_cnt++;
            $display("unexpected %0t wait ran out", $time);
            close_out();
        end
    endtask
    task automatic t_req(input logic [1:0] k, input logic [7:0] i,
        input logic [9:0] ml);
        desc_kind <= k;
        desc_index <= i;
        desc_max_len <= ml;
        desc_req <= 1'b1;
        @(posedge clk_sys);
        desc_req <= 1'b0;
    endtask
    // Far side stalls every other cycle
    task automatic t_desc(input logic [1:0] k, input logic [7:0] i,
        input logic [9:0] ml, input logic [9:0] a, input logic [9:0] n);
        logic [9:0] got;
        got = 10'h0;
        t_req(k, i, ml);
        for (int w = 0; w < 600 && got < n; w++) begin
            @(posedge clk_sys);
            desc_ready <= w[0];
            if (desc_valid_q && desc_ready) begin
                chk(desc_byte_q, rom_at(a + got));
                chk(desc_last_q, got == n - 10'h1);
                got++;
            end
        end
        chk(got, n);
        wait_val(desc_busy, 1'b0, 4);
    endtask
    task automatic t_stall(input logic [1:0] k, input logic [7:0] i,
        input logic [9:0] ml);
        t_req(k, i, ml);
        @(posedge clk_sys);
        chk(desc_stall_q, 1'b1);
        chk(desc_valid_q, 1'b0);
    endtask
    task automatic t_enum;
        chk(usb_ready, 1'b0);
        usb_enum_done <= 1'b1;
        @(posedge clk_sys);
        usb_enum_done <= 1'b0;
        wait_val(usb_ready, 1'b1, 4);
        @(posedge clk_sys);
    endtask
    task automatic t_ident(input logic kbd);
        logic seen;
        kbd_mode <= kbd;
        plugged <= 1'b1;
        wait_val(bus_attach_control, 1'b0, 20000);
        chk(cmd_ok, 1'b1);
        t_req(`USBSD_KIND_DEV, 8'h00, 10'h3ff);
        @(posedge clk_sys);
        chk(desc_busy, 1'b0);
        wait_val(bus_attach_control, 1'b1, DET + 10);
        seen = usb_interface_init;
        repeat (2) begin
            @(posedge clk_sys);
            seen |= usb_interface_init;
        end
        chk(seen, 1'b1);
        chk(keyboard_present_flag, kbd);
        t_enum();
    endtask
    task automatic t_unplug;
        plugged <= 1'b0;
        repeat (RXTO + 20) @(posedge clk_sys);
        chk(keyboard_present_flag, 1'b0);
        chk(rx_seen, 8'h1c);
        chk(bus_attach_control, 1'b1);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (11) @(posedge clk_sys);
        chk({bus_attach_control, usb_core_hold, usb_ready}, 3'h6);
        chk({keyboard_present_flag, kbm_clk_oe_b, kbm_dat_oe_b}, 3'h3);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_enum();
        t_desc(`USBSD_KIND_DEV, 8'h00, 10'h3ff, `USBSD_DEV_MSE_ADR,
            `USBSD_DEV_LEN);
        t_desc(`USBSD_KIND_CFG, 8'h00, 10'h005, `USBSD_CFG_MSE_ADR, 10'h5);
        t_desc(`USBSD_KIND_STR, 8'h0a, 10'h3ff, `USBSD_STR_BASE + 10'h140,
            `USBSD_STR_LEN);
        t_stall(`USBSD_KIND_STR, 8'h0b, 10'h3ff);
        t_stall(`USBSD_KIND_DEV, 8'h00, 10'h000);
        t_ident(1'b1);
        t_desc(`USBSD_KIND_DEV, 8'h00, 10'h3ff, `USBSD_DEV_KBD_ADR,
            `USBSD_DEV_LEN);
        t_desc(`USBSD_KIND_CFG, 8'h00, 10'h3ff, `USBSD_CFG_KBD_ADR,
            `USBSD_CFG_LEN);
        t_desc(`USBSD_KIND_RPT, 8'h00, 10'h3ff, `USBSD_RPT_KBD_ADR,
            `USBSD_RPT_KBD_LEN);
        t_desc(`USBSD_KIND_STR, 8'h00, 10'h3ff, `USBSD_STR_BASE,
            `USBSD_STR_LEN);
        t_unplug();
        t_ident(1'b0);
        t_desc(`USBSD_KIND_RPT, 8'h00, 10'h3ff, `USBSD_RPT_MSE_ADR,
            `USBSD_RPT_MSE_LEN);
        close_out();
    end
endmodule // usb_soft_detach_descriptor_select_tb
bind usbsd_core usbsd_sva #(.DETACH_CYC(DETACH_CYC), .RX_TO_CYC(RX_TO_CYC))
    usbsd_sva_inst (.*);

// [usbsd_core.v]
/*
 * Soft detach and descriptor select: identifies the device on the two-wire
 * keyboard/mouse port, detaches from USB and re-enumerates as keyboard or
 * mouse, and streams the matching descriptor bytes from an external store.
 * Assumes a combinational descriptor store on desc_rom_addr/desc_rom_data,
 * a USB core that obeys usb_core_hold, and inputs synchronous to clk_sys.
 */
`timescale 1ns/1ps
`include "usbsd_defs.vh"

// Function
// - Clear attach control to drop the pull-up
// - Keep pull-up off 50 ms, then reattach
// - Reinitialise USB interface, await host enumeration
// - Data line fall starts a receive
// - Timeout with data low means unplugged
// - Both lines high means peripheral plugged in
// - Send identify request, classify from answer
// - Identify is F2, acknowledge is FA
// - After identification, detach and re-enumerate as class
// - Keyboard flag high only while keyboard attached
// - Start address chosen by keyboard flag
// - Send bytes at incrementing addresses until done
// - String lookup ignores the keyboard flag
module usbsd_core #(
    parameter DETACH_CYC = `USBSD_DETACH_MS * 1000 * `USBSD_CLK_MHZ,
    parameter RX_TO_CYC = `USBSD_RX_TO_US * `USBSD_CLK_MHZ,
    parameter ID_WAIT_CYC = `USBSD_ID_WAIT_US * `USBSD_CLK_MHZ,
    parameter SETTLE_CYC = `USBSD_SETTLE_MS * 1000 * `USBSD_CLK_MHZ
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_b,
    // Keyboard/mouse port, open drain
    input wire kbm_clk_i,
    output wire kbm_clk_o,
    output wire kbm_clk_oe_b,
    input wire kbm_dat_i,
    output wire kbm_dat_o,
    output wire kbm_dat_oe_b,
    // Received bytes in normal operation
    output reg [7:0] kbm_rx_byte_q,
    output reg kbm_rx_valid_q,
    output wire keyboard_present_flag,
    // USB attach and core control
    output wire bus_attach_control,
    output wire usb_interface_init,
    output wire usb_core_hold,
    output wire usb_ready,
    input wire usb_enum_done,
    // Descriptor requests
    input wire desc_req,
    input wire [1:0] desc_kind,
    input wire [7:0] desc_index,
    input wire [9:0] desc_max_len,
    output wire desc_busy,
    output reg desc_stall_q,
    // Descriptor byte stream
    output reg [7:0] desc_byte_q,
    output reg desc_valid_q,
    output reg desc_last_q,
    input wire desc_ready,
    // Descriptor store
    output reg [9:0] desc_rom_addr_q,
    input wire [7:0] desc_rom_data
);

    localparam RTS_CYC = `USBSD_RTS_US * `USBSD_CLK_MHZ;

    // Link states
    localparam [6:0] L_IDLE = 7'h01;
    localparam [6:0] L_RX = 7'h02;
    localparam [6:0] L_UNPLUG = 7'h04;
    localparam [6:0] L_SETTLE = 7'h08;
    localparam [6:0] L_RTS = 7'h10;
    localparam [6:0] L_TX = 7'h20;
    localparam [6:0] L_IDWAIT = 7'h40;

    // USB states
    localparam [3:0] U_RUN = 4'h1;
    localparam [3:0] U_DETACH = 4'h2;
    localparam [3:0] U_INIT = 4'h4;
    localparam [3:0] U_ENUM = 4'h8;

    // Identification phases
    localparam [1:0] ID_ACK = 2'h0;
    localparam [1:0] ID_FIRST = 2'h1;
    localparam [1:0] ID_SECOND = 2'h2;
    localparam [1:0] ID_DONE = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Port link: receive, unplug detection, identify request

    reg [6:0] lnk_q;
    reg [31:0] ltmr_q;
    reg [1:0] id_ph_q;
    reg [10:0] rx_sh_q;
    reg [9:0] tx_sh_q;
    reg [3:0] bit_q;
    reg clk_prev_q;
    reg dat_prev_q;
    reg drv_clk_q;
    reg drv_dat_q;
    reg kbd_q;
    reg det_req_q;

    wire clk_fall = clk_prev_q & ~kbm_clk_i;
    wire dat_fall = dat_prev_q & ~kbm_dat_i;
    wire [10:0] rx_word = {kbm_dat_i, rx_sh_q[10:1]};
    wire rx_ok = ~rx_word[0] & rx_word[10] & (^rx_word[9:1]);
    wire [7:0] rx_data = rx_word[8:1];

    // Only the low level is ever driven; release lets the pull-up win
    assign kbm_clk_o = 1'b0;
    assign kbm_dat_o = 1'b0;
    assign kbm_clk_oe_b = ~drv_clk_q;
    assign kbm_dat_oe_b = ~drv_dat_q;
    assign keyboard_present_flag = kbd_q;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lnk_q <= L_UNPLUG;
            ltmr_q <= 32'h0;
            id_ph_q <= ID_ACK;
            rx_sh_q <= 11'h0;
            tx_sh_q <= 10'h0;
            bit_q <= 4'h0;
            clk_prev_q <= 1'b1;
            dat_prev_q <= 1'b1;
            drv_clk_q <= 1'b0;
            drv_dat_q <= 1'b0;
            kbd_q <= 1'b0;
            det_req_q <= 1'b0;
            kbm_rx_byte_q <= 8'h0;
            kbm_rx_valid_q <= 1'b0;
        end else begin
            clk_prev_q <= kbm_clk_i;
            dat_prev_q <= kbm_dat_i;
            det_req_q <= 1'b0;
            kbm_rx_valid_q <= 1'b0;
            case (lnk_q)
                L_IDLE: begin
                    ltmr_q <= 32'h0;
                    if (dat_fall) begin
                        lnk_q <= L_RX;
                        bit_q <= 4'h0;
                    end
                end
                L_RX: begin
                    if (clk_fall) begin
                        ltmr_q <= 32'h0;
                        rx_sh_q <= rx_word;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'ha) begin
                            lnk_q <= L_IDLE;
                            if (rx_ok) begin
                                case (id_ph_q)
                                    ID_ACK: begin
                                        if (rx_data == `USBSD_RSP_ACK)
                                            id_ph_q <= ID_FIRST;
                                    end
                                    ID_FIRST: begin
                                        id_ph_q <= ID_SECOND;
                                        lnk_q <= L_IDWAIT;
                                    end
                                    ID_SECOND: begin
                                        // Two ID bytes: a keyboard
                                        id_ph_q <= ID_DONE;
                                        kbd_q <= 1'b1;
                                        det_req_q <= 1'b1;
                                    end
                                    default: begin
                                        kbm_rx_byte_q <= rx_data;
                                        kbm_rx_valid_q <= 1'b1;
                                    end
                                endcase
                            end
                        end
                    end else if (ltmr_q >= RX_TO_CYC - 1) begin
                        ltmr_q <= 32'h0;
                        if (!kbm_dat_i) begin
                            lnk_q <= L_UNPLUG;
                            kbd_q <= 1'b0;
                        end else begin
                            lnk_q <= L_IDLE;
                        end
                    end else begin
                        ltmr_q <= ltmr_q + 32'h1;
                    end
                end
                L_IDWAIT: begin
                    // Mouse answers one ID byte, a keyboard sends two
                    if (dat_fall) begin
                        lnk_q <= L_RX;
                        bit_q <= 4'h0;
                        ltmr_q <= 32'h0;
                    end else if (ltmr_q >= ID_WAIT_CYC - 1) begin
                        lnk_q <= L_IDLE;
                        id_ph_q <= ID_DONE;
                        kbd_q <= 1'b0;
                        det_req_q <= 1'b1;
                    end else begin
                        ltmr_q <= ltmr_q + 32'h1;
                    end
                end
                L_UNPLUG: begin
                    ltmr_q <= 32'h0;
                    drv_clk_q <= 1'b0;
                    drv_dat_q <= 1'b0;
                    id_ph_q <= ID_ACK;
                    if (kbm_clk_i && kbm_dat_i)
                        lnk_q <= L_SETTLE;
                end
                L_SETTLE: begin
                    // Lets a fresh peripheral finish its power-up test
                    if (!(kbm_clk_i && kbm_dat_i)) begin
                        lnk_q <= L_UNPLUG;
                    end else if (ltmr_q >= SETTLE_CYC - 1) begin
                        ltmr_q <= 32'h0;
                        lnk_q <= L_RTS;
                        drv_clk_q <= 1'b1;
                    end else begin
                        ltmr_q <= ltmr_q + 32'h1;
                    end
                end
                L_RTS: begin
                    if (ltmr_q >= RTS_CYC - 1) begin
                        ltmr_q <= 32'h0;
                        drv_clk_q <= 1'b0;
                        drv_dat_q <= 1'b1;
                        tx_sh_q <= {1'b1, ~^`USBSD_CMD_IDENT,
                                    `USBSD_CMD_IDENT};
                        bit_q <= 4'h0;
                        lnk_q <= L_TX;
                    end else begin
                        ltmr_q <= ltmr_q + 32'h1;
                    end
                end
                L_TX: begin
                    if (clk_fall) begin
                        ltmr_q <= 32'h0;
                        bit_q <= bit_q + 4'h1;
                        drv_dat_q <= ~tx_sh_q[0];
                        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                        if (bit_q == 4'ha) begin
                            drv_dat_q <= 1'b0;
                            lnk_q <= L_IDLE;
                        end
                    end else if (ltmr_q >= RX_TO_CYC - 1) begin
                        // Silent peripheral: release and look again
                        drv_dat_q <= 1'b0;
                        lnk_q <= L_UNPLUG;
                    end else begin
                        ltmr_q <= ltmr_q + 32'h1;
                    end
                end
                default: begin
                    lnk_q <= L_UNPLUG;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // USB attach sequencing

    reg [3:0] usb_q;
    reg [31:0] utmr_q;

    assign bus_attach_control = ~usb_q[1];
    assign usb_interface_init = usb_q[2];
    assign usb_core_hold = usb_q[1] | usb_q[2];
    assign usb_ready = usb_q[0];

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            usb_q <= U_INIT;
            utmr_q <= 32'h0;
        end else begin
            case (usb_q)
                U_RUN, U_ENUM: begin
                    utmr_q <= 32'h0;
                    if (det_req_q)
                        usb_q <= U_DETACH;
                    else if (usb_q == U_ENUM && usb_enum_done)
                        usb_q <= U_RUN;
                end
                U_DETACH: begin
                    // A new identification restarts the wait
                    if (det_req_q) begin
                        utmr_q <= 32'h0;
                    end else if (utmr_q >= DETACH_CYC - 1) begin
                        utmr_q <= 32'h0;
                        usb_q <= U_INIT;
                    end else begin
                        utmr_q <= utmr_q + 32'h1;
                    end
                end
                U_INIT: begin
                    usb_q <= U_ENUM;
                end
                default: begin
                    usb_q <= U_INIT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Descriptor fetch and stream

    reg dsend_q;
    reg [9:0] dcnt_q;
    reg [9:0] start_d;
    reg [9:0] len_d;
    reg bad_d;

    wire can_load = ~desc_valid_q | desc_ready;

    assign desc_busy = dsend_q;

    always @* begin
        bad_d = 1'b0;
        case (desc_kind)
            `USBSD_KIND_DEV: begin
                start_d = kbd_q ? `USBSD_DEV_KBD_ADR
                                : `USBSD_DEV_MSE_ADR;
                len_d = `USBSD_DEV_LEN;
            end
            `USBSD_KIND_CFG: begin
                start_d = kbd_q ? `USBSD_CFG_KBD_ADR
                                : `USBSD_CFG_MSE_ADR;
                len_d = `USBSD_CFG_LEN;
            end
            `USBSD_KIND_RPT: begin
                start_d = kbd_q ? `USBSD_RPT_KBD_ADR
                                : `USBSD_RPT_MSE_ADR;
                len_d = kbd_q ? `USBSD_RPT_KBD_LEN : `USBSD_RPT_MSE_LEN;
            end
            default: begin
                start_d = `USBSD_STR_BASE + {desc_index[4:0], 5'h0};
                len_d = `USBSD_STR_LEN;
                bad_d = desc_index > `USBSD_STR_MAX;
            end
        endcase
        // Host may ask for fewer bytes than the descriptor holds
        if (desc_max_len < len_d)
            len_d = desc_max_len;
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dsend_q <= 1'b0;
            dcnt_q <= 10'h0;
            desc_rom_addr_q <= 10'h0;
            desc_byte_q <= 8'h0;
            desc_valid_q <= 1'b0;
            desc_last_q <= 1'b0;
            desc_stall_q <= 1'b0;
        end else begin
            desc_stall_q <= 1'b0;
            if (usb_core_hold) begin
                // Transfers in flight are dropped with the bus
                dsend_q <= 1'b0;
                desc_valid_q <= 1'b0;
                desc_last_q <= 1'b0;
            end else if (!dsend_q) begin
                if (desc_ready)
                    desc_valid_q <= 1'b0;
                if (desc_req && !bad_d && len_d != 10'h0) begin
                    dsend_q <= 1'b1;
                    desc_rom_addr_q <= start_d;
                    dcnt_q <= len_d;
                end else if (desc_req) begin
                    desc_stall_q <= 1'b1;
                end
            end else if (can_load) begin
                if (dcnt_q != 10'h0) begin
                    desc_byte_q <= desc_rom_data;
                    desc_valid_q <= 1'b1;
                    desc_last_q <= (dcnt_q == 10'h1);
                    desc_rom_addr_q <= desc_rom_addr_q + 10'h1;
                    dcnt_q <= dcnt_q - 10'h1;
                end else begin
                    desc_valid_q <= 1'b0;
                    desc_last_q <= 1'b0;
                    dsend_q <= 1'b0;
                end
            end
        end
    end

endmodule // usbsd_core

// [usbsd_defs.vh]
/*
 * Constants for the soft-detach and descriptor-select block: command and
 * answer codes of the keyboard/mouse port, descriptor map, timing figures.
 * Assumes a 100 MHz system clock and a descriptor store of 1024 bytes.
 */
`ifndef USBSD_DEFS_VH
`define USBSD_DEFS_VH

// Clock rate
`define USBSD_CLK_MHZ 100

// Timing figures, in their own units
`define USBSD_DETACH_MS 50
`define USBSD_RX_TO_US 2000
`define USBSD_RTS_US 100
`define USBSD_ID_WAIT_US 20000
`define USBSD_SETTLE_MS 500

// Peripheral port codes
`define USBSD_CMD_IDENT 8'hf2
`define USBSD_RSP_ACK 8'hfa

// Descriptor kinds on desc_kind
`define USBSD_KIND_DEV 2'h0
`define USBSD_KIND_CFG 2'h1
`define USBSD_KIND_RPT 2'h2
`define USBSD_KIND_STR 2'h3

// Descriptor map: start address and length, mouse set then keyboard set
`define USBSD_DEV_MSE_ADR 10'h000
`define USBSD_DEV_KBD_ADR 10'h012
`define USBSD_DEV_LEN 10'h012
`define USBSD_CFG_MSE_ADR 10'h024
`define USBSD_CFG_KBD_ADR 10'h046
`define USBSD_CFG_LEN 10'h022
`define USBSD_RPT_MSE_ADR 10'h068
`define USBSD_RPT_MSE_LEN 10'h032
`define USBSD_RPT_KBD_ADR 10'h0a0
`define USBSD_RPT_KBD_LEN 10'h03f

// Strings: one 32-byte slot per index, indexes 0 to 10 shared by both sets
`define USBSD_STR_BASE 10'h100
`define USBSD_STR_LEN 10'h020
`define USBSD_STR_MAX 8'h0a

`endif

// [usbsd_kbm_model.sv]
/*
 * Behavioural keyboard or mouse on the two-wire port.
 * Assumes open-drain lines with pull-ups; bench sets plug state and kind.
 */
`timescale 1ns/1ps
module usbsd_kbm_model #(
    parameter int HALF = 8,
    parameter logic [7:0] ID_A = 8'h5a, // Arbitrary value
    parameter logic [7:0] ID_B = 8'h3c, // Arbitrary value
    parameter logic [7:0] RPT_B = 8'h1c // Report byte after identification
) (
    // Clock and bench control
    input wire logic clk_sys,
    input wire logic plugged,
    input wire logic kbd_mode,
    // Port lines
    input wire logic kbm_clk_oe_b,
    input wire logic kbm_dat_oe_b,
    output logic kbm_clk_i,
    output logic kbm_dat_i,
    // Identify request seen intact
    output logic cmd_ok
);
    logic clk_lo_q = 1'b0;
    logic dat_lo_q = 1'b0;
    logic [9:0] rx_bits;
    // Unplugged: data sinks low, clock floats high
    assign kbm_clk_i = kbm_clk_oe_b & ~clk_lo_q;
    assign kbm_dat_i = kbm_dat_oe_b & ~dat_lo_q & plugged;
    ////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic pulse_clk;
        clk_lo_q <= 1'b1;
        cyc(HALF);
        clk_lo_q <= 1'b0;
        cyc(HALF);
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ~^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            dat_lo_q <= ~f[i];
            cyc(HALF);
            pulse_clk();
        end
        dat_lo_q <= 1'b0;
        cyc(2 * HALF);
    endtask
    ////////////////////////////////////////
    initial cmd_ok = 1'b0;
    always begin
        @(posedge clk_sys);
        if (!plugged)
            cmd_ok <= 1'b0;
        if (plugged && !kbm_clk_oe_b) begin
            while (!kbm_clk_oe_b) @(posedge clk_sys);
            cyc(HALF);
            for (int i = 0; i < 10; i++) begin
                pulse_clk();
                rx_bits[i] = kbm_dat_i;
            end
            dat_lo_q <= 1'b1;
            pulse_clk();
            dat_lo_q <= 1'b0;
            cmd_ok <= rx_bits == {1'b1, ~^8'hf2, 8'hf2};
            cyc(4 * HALF);
            send_byte(8'hfa);
            send_byte(ID_A);
            if (kbd_mode) begin
                send_byte(ID_B);
                send_byte(RPT_B);
            end
        end
    end
endmodule // usbsd_kbm_model

// [usbsd_sva.sv]
/*
 * Checker for the soft-detach and descriptor-select core.
 * Assumes binding into usbsd_core with its two shortened counts.
 */
`timescale 1ns/1ps
`include "usbsd_defs.vh"
module usbsd_sva #(
    parameter DETACH_CYC = 50,
    parameter RX_TO_CYC = 40
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Port lines
    input wire logic kbm_clk_i,
    input wire logic kbm_dat_i,
    // Attach and USB control
    input wire logic keyboard_present_flag,
    input wire logic bus_attach_control,
    input wire logic usb_interface_init,
    input wire logic usb_core_hold,
    input wire logic usb_ready,
    // Descriptor side
    input wire logic desc_req,
    input wire logic [1:0] desc_kind,
    input wire logic [7:0] desc_index,
    input wire logic [9:0] desc_max_len,
    input wire logic desc_busy,
    input wire logic desc_stall_q,
    input wire logic [7:0] desc_byte_q,
    input wire logic desc_valid_q,
    input wire logic desc_last_q,
    input wire logic desc_ready,
    input wire logic [9:0] desc_rom_addr_q
);
    ////////////////////////////////////////
    int det_q;
    int low_q;
    wire take = desc_req && !desc_busy && !usb_core_hold;
    // Saturating, so a long unplug cannot wrap the count
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            det_q <= 0;
            low_q <= 0;
        end else begin
            det_q <= bus_attach_control ? 0 : det_q + 1;
            if (kbm_dat_i || !kbm_clk_i)
                low_q <= 0;
            else if (low_q < RX_TO_CYC + 8)
                low_q <= low_q + 1;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_DETACH_LEN: assert property ($rose(bus_attach_control) |->
        det_q >= DETACH_CYC && det_q <= DETACH_CYC + 1)
        else $error("pull-up off for wrong time");
    AST_INIT_AFTER: assert property ($rose(bus_attach_control) |->
        ##[0:2] usb_interface_init) else $error("no reinit after attach");
    AST_HOLD_OFF: assert property (!bus_attach_control |->
        usb_core_hold && !desc_valid_q && !usb_ready)
        else $error("usb side active while detached");
    AST_DEV_START: assert property (take && desc_max_len != 10'h0 &&
        desc_kind == `USBSD_KIND_DEV |=> desc_rom_addr_q ==
        ($past(keyboard_present_flag) ? `USBSD_DEV_KBD_ADR :
        `USBSD_DEV_MSE_ADR)) else $error("wrong device start");
    AST_STR_ADDR: assert property (take && desc_max_len != 10'h0 &&
        desc_kind == `USBSD_KIND_STR && desc_index <= `USBSD_STR_MAX |=>
        desc_rom_addr_q == `USBSD_STR_BASE + {$past(desc_index), 5'h0})
        else $error("wrong string start");
    AST_STR_STALL: assert property (take && desc_kind == `USBSD_KIND_STR
        && desc_index > `USBSD_STR_MAX |=> desc_stall_q)
        else $error("bad string index not refused");
    AST_ADDR_STEP: assert property (desc_valid_q && desc_ready &&
        !desc_last_q && !usb_core_hold |=> desc_valid_q &&
        desc_rom_addr_q == $past(desc_rom_addr_q) + 10'h1)
        else $error("store address did not step");
    AST_BYTE_STANDS: assert property (desc_valid_q && !desc_ready &&
        !usb_core_hold |=> desc_valid_q && $stable(desc_byte_q) &&
        $stable(desc_last_q)) else $error("byte changed while stalled");
    AST_UNPLUG_CLR: assert property (low_q == RX_TO_CYC + 8 |->
        !keyboard_present_flag) else $error("flag kept after unplug");
    cover property ($fell(bus_attach_control));
    cover property (desc_valid_q && desc_ready && desc_last_q);
    cover property ($rose(keyboard_present_flag));
endmodule // usbsd_sva
